// ---- adc_ctrl_pkg.sv ----
// constants, register map and carrier types for the converter control block
// Behaviour
// R1: each conversion yields one twelve-bit result
// R2: align 0: high=D11..D4, low upper nibble=D3..D0
// R3: align 1: high low nibble=D11..D8, low=D7..D0
// R4: unused result bits always read zero
// R5: converter disabled keeps both result registers unchanged
// R6: conversion starts after start written high then low
// R7: busy high from start until conversion completes
// R8: converter works only while enable is set
// R9: channel codes 3..7 route external inputs, others float
// R10: source field decodes external, supply, amplifier, ground
// R11: internal source disconnects external channel always
// R12: conversion clock is system clock over two-power
// R13: software enables amplifier whenever its output used
// R14: bandgap amplifier input disconnects reference input pin
// R15: software enables bandgap before selecting it
// R16: analog pin loses digital function and pull-high
// R17: unimplemented control bits ignore writes, read zero
// R18: reference select: supply, reference pin, amplifier output
// R19: completion raises the converter interrupt request
// R20: both result bytes update together as busy clears
package adc_ctrl_pkg;

    // ==================== register map
    localparam logic [4:0] ADDR_RESULT_LOW = 5'h00;
    localparam logic [4:0] ADDR_RESULT_HIGH = 5'h04;
    localparam logic [4:0] ADDR_CONTROL_MAIN = 5'h08;
    localparam logic [4:0] ADDR_SOURCE_CLOCK = 5'h0c;
    localparam logic [4:0] ADDR_AMP_REFERENCE = 5'h10;
    localparam logic [4:0] ADDR_BANDGAP = 5'h14;

    // ==================== field positions
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_ALIGN = 4;
    localparam int BIT_AMP_ENABLE = 7;
    localparam int BIT_AMP_INPUT = 4;

    // ==================== writable masks, reset values
    localparam logic [7:0] MASK_CONTROL_MAIN = 8'hbf;
    localparam logic [7:0] MASK_SOURCE_CLOCK = 8'hf7;
    localparam logic [7:0] MASK_AMP_REFERENCE = 8'h9f;
    localparam logic [7:0] MASK_BANDGAP = 8'h01;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [11:0] RESET_RESULT = 12'h000;

    // ==================== codes
    localparam logic [3:0] CHAN_FIRST = 4'h3;
    localparam logic [3:0] CHAN_LAST = 4'h7;
    localparam int NUM_CHANNELS = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // converter input choice
    typedef enum logic [2:0] {
        SRC_EXTERNAL = 3'h0,
        SRC_SUPPLY = 3'h1,
        SRC_SUPPLY_HALF = 3'h2,
        SRC_SUPPLY_QUARTER = 3'h3,
        SRC_AMP = 3'h4,
        SRC_AMP_HALF = 3'h5,
        SRC_AMP_QUARTER = 3'h6,
        SRC_GROUND = 3'h7
    } source_t;

    // reference choice
    typedef enum logic [1:0] {
        REF_SUPPLY = 2'h0,
        REF_PIN = 2'h1,
        REF_AMP = 2'h2
    } reference_t;

    // controls toward the analog front end
    typedef struct packed {
        source_t source;
        logic [NUM_CHANNELS-1:0] channel_connect;
        reference_t reference;
        logic ref_pin_connect;
        logic amp_enable;
        logic amp_from_bandgap;
        logic amp_ref_pin_connect;
        logic [1:0] gain;
        logic bandgap_enable;
        logic conv_power;
    } analog_ctrl_t;

    // interface to the converter core
    typedef struct packed {
        logic start;
        logic clock_tick;
    } core_req_t;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } core_resp_t;

endpackage

// ---- adc_control_registers.sv ----
// converter control registers with an AXI4-Lite slave port
`timescale 1ns/1ps
module adc_control_registers
    import adc_ctrl_pkg::*;
#(
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter core
    output core_req_t core_req,
    input wire core_resp_t core_resp,
    // analog front end
    output analog_ctrl_t analog_ctrl,
    // pin sharing
    input wire logic [NUM_CHANNELS-1:0] pin_analog_mode,
    output logic [NUM_CHANNELS-1:0] pin_digital_off,
    output logic [NUM_CHANNELS-1:0] pin_pullup_off,
    // completion event
    output logic conv_done_irq
);

    // ==================== parameter check
    // the divider must reach the largest step of the clock field
    if (DIV_BITS != 7) begin : g_bad_div
        $error("DIV_BITS must equal the largest divide exponent");
    end

    if (CHAN_LAST - CHAN_FIRST + 1 != NUM_CHANNELS) begin : g_bad_chan
        $error("NUM_CHANNELS must match the routed channel codes");
    end

    // ==================== state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_BUSY = 3'b100
    } conv_state_t;

    conv_state_t state;
    conv_state_t next_state;

    logic [7:0] control_main;
    logic [7:0] source_clock;
    logic [7:0] amp_reference;
    logic [7:0] bandgap_control;
    logic [11:0] result;
    logic [DIV_BITS-1:0] div_count;

    logic aw_held;
    logic w_held;
    logic [4:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;

    // ==================== field views
    wire logic conv_enable = control_main[BIT_ENABLE];
    wire logic start_bit = control_main[BIT_START];
    wire logic result_align_sel = control_main[BIT_ALIGN];
    wire logic [3:0] ext_channel_sel = control_main[3:0];

    wire logic [3:0] input_source_sel = source_clock[7:4];
    wire logic [2:0] conv_clock_div_sel = source_clock[2:0];

    wire logic gain_amp_enable = amp_reference[BIT_AMP_ENABLE];
    wire logic gain_amp_input_sel = amp_reference[BIT_AMP_INPUT];
    wire logic [1:0] reference_sel = amp_reference[3:2];
    wire logic [1:0] gain_sel = amp_reference[1:0];

    wire logic bandgap_enable = bandgap_control[0];

    wire logic conv_busy_flag = (state == ST_BUSY);

    // ==================== write path decode
    // a write lands only once address and data are both held, in either order
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_main = do_write && w_lane && (aw_addr == ADDR_CONTROL_MAIN);
    wire logic wr_source = do_write && w_lane && (aw_addr == ADDR_SOURCE_CLOCK);
    wire logic wr_amp = do_write && w_lane && (aw_addr == ADDR_AMP_REFERENCE);
    wire logic wr_bandgap = do_write && w_lane && (aw_addr == ADDR_BANDGAP);
    wire logic wr_mapped = (aw_addr == ADDR_RESULT_LOW)
        || (aw_addr == ADDR_RESULT_HIGH)
        || (aw_addr == ADDR_CONTROL_MAIN)
        || (aw_addr == ADDR_SOURCE_CLOCK)
        || (aw_addr == ADDR_AMP_REFERENCE)
        || (aw_addr == ADDR_BANDGAP);

    // R17 unimplemented bits dropped on write
    wire logic [7:0] next_main_sw = w_byte & MASK_CONTROL_MAIN;
    wire logic [7:0] next_source = w_byte & MASK_SOURCE_CLOCK;
    wire logic [7:0] next_amp = w_byte & MASK_AMP_REFERENCE;
    wire logic [7:0] next_bandgap = w_byte & MASK_BANDGAP;

    // R6 falling edge of start, written by software
    wire logic start_fall = wr_main && start_bit && !next_main_sw[BIT_START];
    wire logic start_rise = wr_main && !start_bit && next_main_sw[BIT_START];

    wire logic enable_after = wr_main ? next_main_sw[BIT_ENABLE] : conv_enable;

    // ==================== conversion sequence
    // R8 a cleared enable aborts and a done result is then discarded
    wire logic conv_done = conv_busy_flag && conv_enable && core_resp.done;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_rise) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // R6 high then low starts the conversion
                if (start_fall && enable_after) begin
                    next_state = ST_BUSY;
                end else if (start_fall) begin
                    next_state = ST_IDLE;
                end
            end
            ST_BUSY: begin
                // R7 busy ends on completion
                if (conv_done || !enable_after) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // R7 one start pulse as the busy phase opens
    wire logic enter_busy = (state == ST_ARMED) && (next_state == ST_BUSY);

    // ==================== result capture
    // R5 R20 one twelve-bit capture at busy clear, only when enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= RESET_RESULT;
        end else if (conv_done) begin
            // R1 full twelve-bit word
            result <= core_resp.data;
        end
    end

    // ==================== conversion clock divider
    // R12 tick every two-power cycles of the system clock
    wire logic [DIV_BITS-1:0] div_mask =
        DIV_BITS'((1 << conv_clock_div_sel) - 1);
    wire logic div_tick = ((div_count & div_mask) == div_mask);

    // the count restarts while disabled, so each enable opens a full divide period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= '0;
        end else if (conv_enable) begin
            div_count <= div_count + 1'b1;
        end else begin
            div_count <= '0;
        end
    end

    // ==================== software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_main <= RESET_BYTE;
            source_clock <= RESET_BYTE;
            amp_reference <= RESET_BYTE;
            bandgap_control <= RESET_BYTE;
        end else begin
            if (wr_main) begin
                control_main <= next_main_sw;
            end
            if (wr_source) begin
                source_clock <= next_source;
            end
            if (wr_amp) begin
                amp_reference <= next_amp;
            end
            if (wr_bandgap) begin
                bandgap_control <= next_bandgap;
            end
        end
    end

    // ==================== axi write channel
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= RESET_BYTE;
            w_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==================== read mux
    // R2 R3 alignment applied to the stored word
    wire logic [7:0] result_high_view = result_align_sel
        ? {4'h0, result[11:8]} : result[11:4];

    // R4 unused positions forced to zero
    wire logic [7:0] result_low_view = result_align_sel
        ? result[7:0] : {result[3:0], 4'h0};

    wire logic [7:0] control_view =
        {control_main[7], conv_busy_flag, control_main[5:0]};

    logic [7:0] read_byte;
    logic read_hit;

    always_comb begin
        read_byte = RESET_BYTE;
        read_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_RESULT_LOW: read_byte = result_low_view;
            ADDR_RESULT_HIGH: read_byte = result_high_view;
            ADDR_CONTROL_MAIN: read_byte = control_view;
            // R17 unimplemented bits read zero
            ADDR_SOURCE_CLOCK: read_byte = source_clock & MASK_SOURCE_CLOCK;
            ADDR_AMP_REFERENCE: read_byte = amp_reference & MASK_AMP_REFERENCE;
            ADDR_BANDGAP: read_byte = bandgap_control & MASK_BANDGAP;
            default: read_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, read_byte};
            s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==================== analog routing
    // R10 source decode
    logic [2:0] source_code;

    always_comb begin
        case (input_source_sel)
            4'h1: source_code = SRC_SUPPLY;
            4'h2: source_code = SRC_SUPPLY_HALF;
            4'h3: source_code = SRC_SUPPLY_QUARTER;
            4'h5: source_code = SRC_AMP;
            4'h6: source_code = SRC_AMP_HALF;
            4'h7: source_code = SRC_AMP_QUARTER;
            4'h8, 4'h9, 4'ha, 4'hb: source_code = SRC_GROUND;
            default: source_code = SRC_EXTERNAL;
        endcase
    end

    wire logic source_external = (source_code == SRC_EXTERNAL);

    wire logic chan_valid = (ext_channel_sel >= CHAN_FIRST)
        && (ext_channel_sel <= CHAN_LAST);
    wire logic [3:0] chan_index = ext_channel_sel - CHAN_FIRST;

    // R9 R11 one channel switch at most, none for internal sources
    logic [NUM_CHANNELS-1:0] next_connect;

    for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
        assign next_connect[i] = source_external && chan_valid
            && (chan_index == 4'(i));
    end

    // R18 reference decode
    wire reference_t ref_code = reference_sel[1]
        ? REF_AMP
        : (reference_sel[0] ? REF_PIN : REF_SUPPLY);

    // front-end controls are registered so switches never glitch on decode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.source <= source_t'(source_code);
            analog_ctrl.channel_connect <= next_connect;
            analog_ctrl.reference <= ref_code;
            analog_ctrl.ref_pin_connect <= (ref_code == REF_PIN);
            analog_ctrl.amp_enable <= gain_amp_enable;
            analog_ctrl.amp_from_bandgap <= gain_amp_input_sel;
            // R14 bandgap input cuts the reference input pin
            analog_ctrl.amp_ref_pin_connect <= !gain_amp_input_sel;
            analog_ctrl.gain <= gain_sel;
            analog_ctrl.bandgap_enable <= bandgap_enable;
            // R8 converter powered only while enabled
            analog_ctrl.conv_power <= conv_enable;
        end
    end

    // ==================== core strobes and pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req <= '0;
            conv_done_irq <= 1'b0;
            pin_digital_off <= '0;
            pin_pullup_off <= '0;
        end else begin
            core_req.start <= enter_busy;
            core_req.clock_tick <= conv_enable && div_tick;
            // R19 request pulse on completion
            conv_done_irq <= conv_done;
            // R16 analog pins drop digital role and pull-high
            pin_digital_off <= pin_analog_mode;
            pin_pullup_off <= pin_analog_mode;
        end
    end

endmodule

// ---- adc_control_registers_asserts.sv ----
// port-level checks for the converter control block
`timescale 1ns/1ps
module adc_control_registers_asserts
    import adc_ctrl_pkg::*;
#(
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // converter side
    input wire core_req_t core_req,
    input wire core_resp_t core_resp,
    input wire analog_ctrl_t analog_ctrl,
    input wire logic [NUM_CHANNELS-1:0] pin_analog_mode,
    input wire logic [NUM_CHANNELS-1:0] pin_digital_off,
    input wire logic [NUM_CHANNELS-1:0] pin_pullup_off,
    input wire logic conv_done_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==================== assertions
    // past reset guard: the copy still holds its reset value one edge after release
    a_pin_release: assert property (
        $past(aresetn) |-> pin_digital_off == $past(pin_analog_mode)
        && pin_pullup_off == pin_digital_off) else $error("pin release wrong");
    a_start_pulse: assert property (
        core_req.start |=> !core_req.start) else $error("start longer than one cycle");
    a_start_power: assert property (
        core_req.start |-> analog_ctrl.conv_power) else $error("start while powered off");
    a_irq_cause: assert property (
        conv_done_irq |-> $past(core_resp.done)) else $error("irq without core done");
    a_irq_single: assert property (
        conv_done_irq |=> !conv_done_irq) else $error("irq longer than one cycle");
    a_irq_power: assert property (
        conv_done_irq |-> $past(analog_ctrl.conv_power)) else $error("capture while off");
    a_chan_onehot: assert property (
        $onehot0(analog_ctrl.channel_connect)) else $error("two channels joined");
    a_internal_off: assert property (
        analog_ctrl.source != SRC_EXTERNAL |-> analog_ctrl.channel_connect == '0)
        else $error("channel joined to internal source");
    a_bandgap_pin: assert property (
        analog_ctrl.amp_from_bandgap |-> !analog_ctrl.amp_ref_pin_connect)
        else $error("reference pin kept with bandgap");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == '0) else $error("upper read bits set");
    // ==================== covers
    c_start: cover property (core_req.start);
    c_done: cover property (conv_done_irq);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind adc_control_registers adc_control_registers_asserts #(.DIV_BITS(DIV_BITS))
    i_adc_control_registers_asserts (.aclk, .aresetn, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .core_req, .core_resp, .analog_ctrl, .pin_analog_mode,
    .pin_digital_off, .pin_pullup_off, .conv_done_irq);

// ---- adc_control_registers_test.sv ----
// self-checking bench for the converter control registers
`timescale 1ns/1ps
module adc_control_registers_test
    import adc_ctrl_pkg::*;
;
    // ==================== signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic conv_done_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    core_req_t core_req;
    core_resp_t core_resp = '0;
    analog_ctrl_t analog_ctrl;
    logic [NUM_CHANNELS-1:0] pin_analog_mode = '0, pin_digital_off, pin_pullup_off;
    logic [33:0] exp_q[$];
    logic start_seen = 1'b0;
    int err_total = 0, n_checks = 0;
    logic [4:0] rw_addr[3] = '{ADDR_SOURCE_CLOCK, ADDR_AMP_REFERENCE, ADDR_BANDGAP};
    logic [7:0] rw_mask[3] = '{MASK_SOURCE_CLOCK, MASK_AMP_REFERENCE, MASK_BANDGAP};

    always #2.5 aclk = ~aclk;

    adc_control_registers #(.DIV_BITS(7)) i_adc_control_registers (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .core_req, .core_resp, .analog_ctrl,
        .pin_analog_mode, .pin_digital_off, .pin_pullup_off, .conv_done_irq);

    // ==================== reporting
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ==================== response watcher
    // readies are sampled at the falling edge, so tasks never race the design's updates
    always @(posedge aclk) begin
        logic [33:0] e;
        pin_analog_mode <= NUM_CHANNELS'($urandom);
        if (core_req.start === 1'b1) begin
            start_seen <= 1'b1;
        end
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            e = exp_q.pop_front();
            check("resp", {30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp}, {30'h0, e[33:32]});
            if (s_axi_rvalid) begin
                check("rdata", s_axi_rdata, e[31:0]);
            end
        end
    end

    // ==================== bus tasks
    task automatic axi_write(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, b_hit;
        int n;
        b_hit = 1'b0;
        n = 0;
        exp_q.push_back({er, 32'h0});
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hit && n < 200) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid === 1'b1;
            n++;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (!b_hit) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic axi_read(input logic [4:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic ar_hit, r_hit;
        int n;
        r_hit = 1'b0;
        n = 0;
        exp_q.push_back({er, 24'h0, ed});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hit && n < 200) begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid === 1'b1;
            n++;
            @(posedge aclk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (!r_hit) begin
            err_total++;
            end_sim();
        end
    endtask

    // ==================== scenario helpers
    function automatic source_t exp_src(input logic [3:0] c);
        case (c)
            4'h1: return SRC_SUPPLY;
            4'h2: return SRC_SUPPLY_HALF;
            4'h3: return SRC_SUPPLY_QUARTER;
            4'h5: return SRC_AMP;
            4'h6: return SRC_AMP_HALF;
            4'h7: return SRC_AMP_QUARTER;
            4'h8, 4'h9, 4'ha, 4'hb: return SRC_GROUND;
            default: return SRC_EXTERNAL;
        endcase
    endfunction

    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        gap = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (core_req.clock_tick !== 1'b1 && n < 300);
        do begin
            @(negedge aclk);
            gap++;
        end while (core_req.clock_tick !== 1'b1 && gap < 300);
        @(posedge aclk);
        if (n >= 300 || gap >= 300) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic convert(input logic [11:0] d, input logic en);
        start_seen = 1'b0;
        axi_write(ADDR_CONTROL_MAIN, {2'b10, en, 5'h00}, RESP_OKAY);
        check("early start", {31'h0, start_seen}, 32'h0);
        axi_write(ADDR_CONTROL_MAIN, {2'b00, en, 5'h00}, RESP_OKAY);
        axi_read(ADDR_CONTROL_MAIN, {1'b0, en, en, 5'h00}, RESP_OKAY);
        check("core start", {31'h0, start_seen}, {31'h0, en});
        check("power", {31'h0, analog_ctrl.conv_power}, {31'h0, en});
        core_resp <= {1'b1, d};
        @(posedge aclk);
        core_resp <= {1'b0, ~d};
        @(negedge aclk);
        check("irq", {31'h0, conv_done_irq}, {31'h0, en});
        @(posedge aclk);
        axi_read(ADDR_CONTROL_MAIN, {2'b00, en, 5'h00}, RESP_OKAY);
    endtask

    task automatic read_result(input logic [11:0] d);
        axi_write(ADDR_CONTROL_MAIN, 8'h20, RESP_OKAY);
        axi_read(ADDR_RESULT_HIGH, d[11:4], RESP_OKAY);
        axi_read(ADDR_RESULT_LOW, {d[3:0], 4'h0}, RESP_OKAY);
        axi_write(ADDR_CONTROL_MAIN, 8'h30, RESP_OKAY);
        axi_read(ADDR_RESULT_HIGH, {4'h0, d[11:8]}, RESP_OKAY);
        axi_read(ADDR_RESULT_LOW, d[7:0], RESP_OKAY);
    endtask

    // ==================== main sequence
    initial begin
        logic [11:0] d;
        int g;
        void'($urandom(67));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 6; a++) axi_read(5'(a * 4), 8'h00, RESP_OKAY);
        axi_read(5'h18, 8'h00, RESP_SLVERR);
        axi_write(5'h18, 8'hff, RESP_SLVERR);
        axi_write(ADDR_RESULT_LOW, 8'hff, RESP_OKAY);
        axi_read(ADDR_RESULT_LOW, 8'h00, RESP_OKAY);
        foreach (rw_addr[i]) begin
            axi_write(rw_addr[i], 8'hff, RESP_OKAY);
            axi_read(rw_addr[i], rw_mask[i], RESP_OKAY);
        end
        axi_write(ADDR_CONTROL_MAIN, 8'h25, RESP_OKAY);
        for (int c = 0; c < 16; c++) begin
            axi_write(ADDR_SOURCE_CLOCK, {4'(c), 4'h0}, RESP_OKAY);
            @(negedge aclk);
            check("source", {29'h0, analog_ctrl.source}, {29'h0, exp_src(4'(c))});
            g = (exp_src(4'(c)) == SRC_EXTERNAL) ? 4 : 0;
            check("internal", {27'h0, analog_ctrl.channel_connect}, g);
            @(posedge aclk);
        end
        for (int c = 0; c < 16; c++) begin
            axi_write(ADDR_CONTROL_MAIN, {4'h2, 4'(c)}, RESP_OKAY);
            @(negedge aclk);
            g = (c >= 3 && c <= 7) ? (1 << (c - 3)) : 0;
            check("channel", {27'h0, analog_ctrl.channel_connect}, g);
            @(posedge aclk);
        end
        for (int i = 0; i < 8; i++) begin
            g = $urandom_range(3);
            axi_write(ADDR_AMP_REFERENCE, {3'b100, i[2], i[1:0], 2'(g)}, RESP_OKAY);
            @(negedge aclk);
            check("reference", {30'h0, analog_ctrl.reference}, i[1] ? 2 : i[0]);
            check("bandgap in", {31'h0, analog_ctrl.amp_from_bandgap}, i[2]);
            check("gain", {30'h0, analog_ctrl.gain}, g);
            @(posedge aclk);
        end
        for (int s = 0; s < 8; s++) begin
            axi_write(ADDR_SOURCE_CLOCK, {5'h00, 3'(s)}, RESP_OKAY);
            tick_gap(g);
            check("tick gap", g, 1 << s);
        end
        for (int k = 0; k < 2; k++) begin
            d = 12'($urandom);
            convert(d, 1'b1);
            read_result(d);
        end
        // converter off: start sequence and stray done must leave the result alone
        convert(~d, 1'b0);
        read_result(d);
        end_sim();
    end
endmodule
